// ==== design/bamp_params.svh ====
`ifndef BAMP_PARAMS_SVH
`define BAMP_PARAMS_SVH

// map geometry
`define BAMP_MAP_COUNT     496
`define BAMP_PAGE_LIMIT    9'd496
`define BAMP_PAGE_BITS     21
`define BAMP_PATH_BITS     4

// map entry layout
`define BAMP_ME_PAGE_MSB   20
`define BAMP_ME_PATH_LSB   21
`define BAMP_ME_PATH_MSB   24
`define BAMP_ME_VALID_BIT  31

// register byte offsets
`define BAMP_MAP_LAST_OFF  12'h7BC
`define BAMP_STATUS_OFF    12'h800
`define BAMP_CTRL_OFF      12'h804
`define BAMP_BNE_OFF       12'h808

// status and control fields
`define BAMP_ST_IVM_BIT    0
`define BAMP_ST_MPF_BIT    1
`define BAMP_CTL_BADPAR    0
`define BAMP_STATUS_RST    2'h0
`define BAMP_CTRL_RST      1'h0

// peripheral control codes
`define BAMP_C_INPUT       2'h0
`define BAMP_C_PAUSE       2'h1
`define BAMP_C_WORD        2'h2
`define BAMP_C_BYTE        2'h3

// byte masks
`define BAMP_MASK_LO_PAIR  4'h3
`define BAMP_MASK_HI_PAIR  4'hC
`define BAMP_MASK_BYTE0    4'h1

`endif

// ==== design/bamp_pkg.sv ====
`default_nettype none
package bamp_pkg;

  // backplane functions
  typedef enum logic [2:0] {
    BAMP_F_READ_MASK,
    BAMP_F_WRITE_MASK,
    BAMP_F_ILK_READ_MASK,
    BAMP_F_ILK_WRITE_MASK,
    BAMP_F_EXT_READ,
    BAMP_F_EXT_WRITE
  } bamp_func_t;

  // backplane request
  typedef struct packed {
    logic [27:0] addr;
    bamp_func_t  func;
    logic [7:0]  mask;
    logic [63:0] wdata;
  } bamp_bp_req_t;

  // peripheral cycle, as seen at the pins
  typedef struct packed {
    logic        msyn;
    logic [17:0] addr;
    logic [1:0]  ctl;
    logic [15:0] wdata;
  } bamp_ub_in_t;

endpackage
`default_nettype wire

// ==== design/bamp_fm_enc.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "bamp_params.svh"
module bamp_fm_enc
(
  input  wire logic [1:0]          ctl,
  input  wire logic [1:0]          lo,
  input  wire logic                interlock,
  output bamp_pkg::bamp_func_t     func,
  output logic [3:0]               mask
);
  import bamp_pkg::*;

  // function and mask from control and low address bits
  always_comb
  begin
    // word picks a byte pair, byte a single lane
    if (ctl == `BAMP_C_BYTE)
      mask = `BAMP_MASK_BYTE0 << lo;
    else
      mask = lo[1] ? `BAMP_MASK_HI_PAIR : `BAMP_MASK_LO_PAIR;
    case (ctl)
      `BAMP_C_INPUT: func = BAMP_F_READ_MASK;
      `BAMP_C_PAUSE: func = BAMP_F_ILK_READ_MASK;
      default:       func = interlock ? BAMP_F_ILK_WRITE_MASK : BAMP_F_WRITE_MASK;
    endcase
  end

endmodule
`default_nettype wire

// ==== design/bamp_adapter.sv ====
// Summary of operation
// - 496 map entries cover the whole peripheral memory space, one per page.
// - every map entry is a separate longword on the register bus.
// - an entry holds backplane page and data path number, written by software.
// - 512-byte pages; page bits 17:9 index map, entry gives backplane bits 27:7.
// - peripheral bits 8:2 pass as backplane bits 6:0 of a 28-bit address on the direct path; buffered paths pass 8:3 as 6:1, bit 0 zero.
// - function and byte mask come from low address bits and control bits.
// - mask selects one or two bytes; function is read or write, plain or locked.
// - sixteen paths; path zero direct, paths one to fifteen buffered.
// - invalid or upper-parity-bad entry withholds acknowledge and sets a flag.
// - lower half parity checked only when a backplane transfer is needed.
// - direct path makes one backplane read or write per peripheral cycle.
// - pause input then output becomes locked read then locked write.
// - interlock flop set by pause input selects locked write next.
// - direct path acknowledges only after the backplane transfer completes.
// - buffered paths move 64-bit quadwords, one per four peripheral cycles.
// - buffered paths serve input, word and byte output, never pause input.
// - buffered paths serve random aligned word data from one quadword.
// - pause input to a buffered path gets no acknowledge at all.
// - write to last word or byte of quadword acks, then flushes valid bytes.
`timescale 1ns/1ns
`default_nettype none
`include "bamp_params.svh"
module bamp_adapter
(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire bamp_pkg::bamp_ub_in_t ub_in,
  output logic                       ub_ack,
  output logic [15:0]                ub_rdata,
  output logic                       bp_valid,
  output bamp_pkg::bamp_bp_req_t     bp_cmd,
  input  wire logic                  bp_done,
  input  wire logic [63:0]           bp_rdata
);
  import bamp_pkg::*;

  typedef enum logic [2:0] {S_IDLE, S_LOOK, S_DIRECT, S_BRD, S_ACK, S_FLUSH, S_ABORT} bamp_st_t;

  // map storage, one entry and two parity bits per page
  logic [31:0]  map_mem [0:`BAMP_MAP_COUNT-1];
  logic [1:0]   map_par [0:`BAMP_MAP_COUNT-1];
  logic [63:0]  buf_data [1:15];
  logic [7:0]   buf_vld  [1:15];
  logic [26:0]  buf_qa   [1:15];
  logic [15:1]  buffer_holds_data;

  bamp_ub_in_t  ub_s1, ub_s2;
  bamp_st_t     state, next_state;
  logic [17:0]  ua, next_ua;
  logic [1:0]   uc, next_uc;
  logic [15:0]  uw, next_uw;
  logic [31:0]  ent, next_ent;
  logic [1:0]   epar, next_epar;
  logic         ilk, next_ilk;
  logic         flush_pend, next_flush_pend;
  logic         ack_r, next_ack;
  logic [15:0]  rd_r, next_rd;
  logic         bpv, next_bpv;
  bamp_bp_req_t cmd, next_cmd;
  logic [1:0]   status, next_status;
  logic         ctrl_badpar, next_ctrl_badpar;
  logic [31:0]  prd_r, next_prd;
  logic         perr_r, next_perr;
  bamp_func_t   enc_func;
  logic [3:0]   enc_mask;
  logic [3:0]   path;
  logic [26:0]  qa;
  logic [7:0]   be8;
  logic [63:0]  merged;
  logic         buf_wr, buf_fill, buf_clr, buf_hit, last_in_quad;
  logic         par_hi_bad, par_lo_bad, map_we, apb_wr, apb_setup;
  logic [9:0]   widx;

  // pins come from another domain: two flops before any use
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ub_s1 <= '0;
      ub_s2 <= '0;
    end
    else
    begin
      ub_s1 <= ub_in;
      ub_s2 <= ub_s1;
    end
  end

  bamp_fm_enc u_enc
  (
    .ctl       (uc),
    .lo        (ua[1:0]),
    .interlock (ilk),
    .func      (enc_func),
    .mask      (enc_mask)
  );

  // entry decode and buffered-path helpers
  assign path         = ent[`BAMP_ME_PATH_MSB:`BAMP_ME_PATH_LSB];
  assign qa           = {ent[`BAMP_ME_PAGE_MSB:0], ua[8:3]};
  assign par_hi_bad   = ^{ent[31:16], epar[1]};
  assign par_lo_bad   = ^{ent[15:0], epar[0]};
  assign be8          = ua[2] ? {enc_mask, 4'h0} : {4'h0, enc_mask};
  assign last_in_quad = (ua[2:1] == 2'h3) && ((uc == `BAMP_C_WORD) || ua[0]);
  assign buf_hit      = (path != 4'h0) && buffer_holds_data[path] && (buf_qa[path] == qa)
                        && (buf_vld[path][{ua[2:1], 1'b0} +: 2] == 2'h3);

  // byte lanes of the quadword image
  genvar gb;
  generate
    for (gb = 0; gb < 8; gb++)
    begin : g_lane
      assign merged[gb*8 +: 8] = be8[gb] ? uw[(gb%2)*8 +: 8] : buf_data[path][gb*8 +: 8];
    end
  endgenerate

  // transfer sequencer next state
  always_comb
  begin
    next_state      = state;
    next_ua         = ua;
    next_uc         = uc;
    next_uw         = uw;
    next_ent        = ent;
    next_epar       = epar;
    next_ilk        = ilk;
    next_flush_pend = flush_pend;
    next_ack        = ack_r;
    next_rd         = rd_r;
    next_bpv        = bpv;
    next_cmd        = cmd;
    next_status     = 2'h0; // set events only, merged with the flags below
    buf_wr          = 1'b0;
    buf_fill        = 1'b0;
    buf_clr         = 1'b0;
    case (state)
      S_IDLE:
        // only memory pages below the register space are answered
        if (ub_s2.msyn && (ub_s2.addr[17:9] < `BAMP_PAGE_LIMIT))
        begin
          next_ua    = ub_s2.addr;
          next_uc    = ub_s2.ctl;
          next_uw    = ub_s2.wdata;
          next_ent   = map_mem[ub_s2.addr[17:9]];
          next_epar  = map_par[ub_s2.addr[17:9]];
          next_state = S_LOOK;
        end
      S_LOOK:
        // invalid entry is a map error
        if (!ent[`BAMP_ME_VALID_BIT])
        begin
          next_status[`BAMP_ST_IVM_BIT] = 1'b1;
          next_state = S_ABORT;
        end
        else if (par_hi_bad)
        begin
          next_status[`BAMP_ST_MPF_BIT] = 1'b1;
          next_state = S_ABORT;
        end
        // path zero is the direct path
        else if (path == 4'h0)
        begin
          if (par_lo_bad)
          begin
            next_status[`BAMP_ST_MPF_BIT] = 1'b1;
            next_state = S_ABORT;
          end
          else
          begin
            next_cmd.addr  = {ent[`BAMP_ME_PAGE_MSB:0], ua[8:2]};
            next_cmd.func  = enc_func;
            next_cmd.mask  = {4'h0, enc_mask};
            next_cmd.wdata = {32'h0, uw, uw};
            next_bpv       = 1'b1;
            next_state     = S_DIRECT;
          end
        end
        else if (uc == `BAMP_C_PAUSE)
          next_state = S_ABORT;
        else if (uc != `BAMP_C_INPUT)
        begin
          buf_wr          = 1'b1;
          next_flush_pend = last_in_quad;
          next_ack        = 1'b1;
          next_state      = S_ACK;
        end
        // word data served from the held quadword
        else if (buf_hit)
        begin
          next_rd    = buf_data[path][ua[2:1]*16 +: 16];
          next_ack   = 1'b1;
          next_state = S_ACK;
        end
        else if (par_lo_bad)
        begin
          next_status[`BAMP_ST_MPF_BIT] = 1'b1;
          next_state = S_ABORT;
        end
        else
        begin
          next_cmd.addr  = {qa, 1'b0};
          next_cmd.func  = BAMP_F_EXT_READ;
          next_cmd.mask  = 8'hFF;
          next_cmd.wdata = 64'h0;
          next_bpv       = 1'b1;
          next_state     = S_BRD;
        end
      S_DIRECT:
        if (bp_done)
        begin
          next_bpv = 1'b0;
          next_rd  = ua[1] ? bp_rdata[31:16] : bp_rdata[15:0];
          // interlock set by pause, released by output
          if (uc == `BAMP_C_PAUSE)
            next_ilk = 1'b1;
          else if (uc != `BAMP_C_INPUT)
            next_ilk = 1'b0;
          next_ack   = 1'b1;
          next_state = S_ACK;
        end
      S_BRD:
        if (bp_done)
        begin
          buf_fill   = 1'b1;
          next_bpv   = 1'b0;
          next_rd    = bp_rdata[ua[2:1]*16 +: 16];
          next_ack   = 1'b1;
          next_state = S_ACK;
        end
      S_ACK:
        // hold acknowledge until the master drops its sync
        if (!ub_s2.msyn)
        begin
          next_ack        = 1'b0;
          next_flush_pend = 1'b0;
          next_state      = S_IDLE;
          // flush the quadword after the peripheral cycle ends
          if (flush_pend && par_lo_bad)
            next_status[`BAMP_ST_MPF_BIT] = 1'b1;
          else if (flush_pend)
          begin
            next_cmd.addr  = {buf_qa[path], 1'b0};
            next_cmd.func  = BAMP_F_EXT_WRITE;
            next_cmd.mask  = buf_vld[path];
            next_cmd.wdata = buf_data[path];
            next_bpv       = 1'b1;
            next_state     = S_FLUSH;
          end
        end
      S_FLUSH:
        // no new peripheral cycle until the write completes
        if (bp_done)
        begin
          buf_clr    = 1'b1;
          next_bpv   = 1'b0;
          next_state = S_IDLE;
        end
      default:
        if (!ub_s2.msyn)
          next_state = S_IDLE;
    endcase
    // status flags: software clears by writing one; a set in the same
    // cycle wins even when the flag was already up
    if (apb_wr && (paddr == `BAMP_STATUS_OFF))
      next_status = next_status | (status & ~pwdata[1:0]);
    else
      next_status = next_status | status;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state      <= S_IDLE;
      ua         <= '0;
      uc         <= '0;
      uw         <= '0;
      ent        <= '0;
      epar       <= '0;
      ilk        <= 1'b0;
      flush_pend <= 1'b0;
      ack_r      <= 1'b0;
      rd_r       <= '0;
      bpv        <= 1'b0;
      cmd        <= '0;
      status     <= `BAMP_STATUS_RST;
    end
    else
    begin
      state      <= next_state;
      ua         <= next_ua;
      uc         <= next_uc;
      uw         <= next_uw;
      ent        <= next_ent;
      epar       <= next_epar;
      ilk        <= next_ilk;
      flush_pend <= next_flush_pend;
      ack_r      <= next_ack;
      rd_r       <= next_rd;
      bpv        <= next_bpv;
      cmd        <= next_cmd;
      status     <= next_status;
    end
  end

  // quadword buffers, valid bytes and occupancy
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      buffer_holds_data <= '0;
    else if (buf_wr || buf_fill)
      buffer_holds_data[path] <= 1'b1;
    else if (buf_clr)
      buffer_holds_data[path] <= 1'b0;
  end

  always_ff @(posedge pclk)
  begin
    if (buf_wr)
    begin
      buf_data[path] <= merged;
      buf_qa[path]   <= qa;
      // a write to a new quadword starts a fresh image
      buf_vld[path]  <= (buffer_holds_data[path] && (buf_qa[path] == qa)) ? (buf_vld[path] | be8) : be8;
    end
    else if (buf_fill)
    begin
      buf_data[path] <= bp_rdata;
      buf_qa[path]   <= qa;
      buf_vld[path]  <= 8'hFF;
    end
    else if (buf_clr)
      buf_vld[path] <= 8'h00;
  end

  // apb slave: zero wait, answer computed in setup phase
  assign apb_setup = psel && !penable;
  assign apb_wr    = psel && penable && pwrite && !perr_r;
  assign map_we    = apb_wr && (paddr <= `BAMP_MAP_LAST_OFF);
  assign widx      = paddr[11:2];
  assign pready    = 1'b1;
  assign pslverr   = psel && penable && perr_r;

  always_comb
  begin
    next_prd         = prd_r;
    next_perr        = perr_r;
    next_ctrl_badpar = ctrl_badpar;
    if (apb_setup)
    begin
      next_perr = 1'b0;
      // each entry has its own longword
      if (paddr[1:0] != 2'h0)
      begin
        next_prd  = 32'h0;
        next_perr = 1'b1;
      end
      else if (paddr <= `BAMP_MAP_LAST_OFF)
        next_prd = map_mem[widx[8:0]];
      else if (paddr == `BAMP_STATUS_OFF)
        next_prd = {30'h0, status};
      else if (paddr == `BAMP_CTRL_OFF)
        next_prd = {31'h0, ctrl_badpar};
      else if (paddr == `BAMP_BNE_OFF)
        next_prd = {16'h0, buffer_holds_data, 1'b0};
      else
      begin
        next_prd  = 32'h0;
        next_perr = 1'b1;
      end
    end
    if (apb_wr && (paddr == `BAMP_CTRL_OFF))
      next_ctrl_badpar = pwdata[`BAMP_CTL_BADPAR];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prd_r       <= '0;
      perr_r      <= 1'b0;
      ctrl_badpar <= `BAMP_CTRL_RST;
    end
    else
    begin
      prd_r       <= next_prd;
      perr_r      <= next_perr;
      ctrl_badpar <= next_ctrl_badpar;
    end
  end

  // software sets page, path and valid; parity made here
  always_ff @(posedge pclk)
  begin
    if (map_we)
    begin
      map_mem[widx[8:0]] <= pwdata;
      map_par[widx[8:0]] <= {^pwdata[31:16] ^ ctrl_badpar, ^pwdata[15:0] ^ ctrl_badpar};
    end
  end

  assign prdata   = prd_r;
  assign ub_ack   = ack_r;
  assign ub_rdata = rd_r;
  assign bp_valid = bpv;
  assign bp_cmd   = cmd;

  // software keeps one device per buffered path; no arbitration here

  // helper: direct-path completion seen for the current cycle
  logic done_seen;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      done_seen <= 1'b0;
    else if (state == S_IDLE)
      done_seen <= 1'b0;
    else if (bp_done && bpv)
      done_seen <= 1'b1;
  end

  property p_abort_no_ack;
    @(posedge pclk) disable iff (!presetn) (state == S_ABORT) |-> !ub_ack;
  endproperty
  a_abort_no_ack: assert property (p_abort_no_ack) else $error("ack during abort");

  property p_invalid_flag;
    @(posedge pclk) disable iff (!presetn)
      (state == S_LOOK && !ent[`BAMP_ME_VALID_BIT]) |=> status[`BAMP_ST_IVM_BIT] ##0 state == S_ABORT;
  endproperty
  a_invalid_flag: assert property (p_invalid_flag) else $error("invalid map not flagged");

  property p_addr_form;
    @(posedge pclk) disable iff (!presetn)
      (bp_valid && state == S_DIRECT)
        |-> bp_cmd.addr == {map_mem[ua[17:9]][`BAMP_ME_PAGE_MSB:0], ua[8:2]};
  endproperty
  a_addr_form: assert property (p_addr_form) else $error("direct address wrong");

  property p_mask_width;
    @(posedge pclk) disable iff (!presetn)
      (bp_valid && state == S_DIRECT) |-> ($countones(bp_cmd.mask) inside {1, 2}) && bp_cmd.mask[7:4] == 4'h0;
  endproperty
  a_mask_width: assert property (p_mask_width) else $error("direct mask not one or two bytes");

  property p_ack_after_done;
    @(posedge pclk) disable iff (!presetn)
      ($rose(ub_ack) && path == 4'h0) |-> done_seen;
  endproperty
  a_ack_after_done: assert property (p_ack_after_done) else $error("direct ack before backplane");

  property p_pause_buffered;
    @(posedge pclk) disable iff (!presetn)
      (state == S_LOOK && ent[`BAMP_ME_VALID_BIT] && !par_hi_bad && path != 4'h0
       && uc == `BAMP_C_PAUSE) |=> (state == S_ABORT) [*2];
  endproperty
  a_pause_buffered: assert property (p_pause_buffered) else $error("pause on buffered path served");

  property p_ilk_write;
    @(posedge pclk) disable iff (!presetn)
      (bp_valid && state == S_DIRECT && ilk && uc[1]) |-> bp_cmd.func == BAMP_F_ILK_WRITE_MASK;
  endproperty
  a_ilk_write: assert property (p_ilk_write) else $error("locked write not used");

  property p_flush_mask;
    @(posedge pclk) disable iff (!presetn)
      (state == S_ACK && !ub_s2.msyn && flush_pend && !par_lo_bad)
        |=> bp_valid && bp_cmd.func == BAMP_F_EXT_WRITE && bp_cmd.mask == $past(buf_vld[path]);
  endproperty
  a_flush_mask: assert property (p_flush_mask) else $error("flush mask not byte validity");

endmodule
`default_nettype wire

// ==== verif/bamp_mem_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module bamp_mem_model
(
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic [3:0]             lat,
  input  wire logic                   bp_valid,
  input  wire bamp_pkg::bamp_bp_req_t bp_cmd,
  output logic                        bp_done,
  output logic [63:0]                 bp_rdata
);
  import bamp_pkg::*;
  logic [3:0]  cnt;
  logic [3:0]  next_cnt;
  logic        next_done;
  logic [63:0] next_rdata;

  // memory is a pattern of the address, so no storage is kept
  always_comb
  begin
    next_cnt   = cnt;
    next_done  = 1'b0;
    next_rdata = ~bp_rdata; // idle data toggles, never the last value
    if (bp_valid && !bp_done)
    begin
      next_cnt = cnt + 4'h1;
      if (cnt >= lat)
      begin
        next_cnt   = 4'h0;
        next_done  = 1'b1;
        next_rdata = {4'hC, bp_cmd.addr, 4'h3, bp_cmd.addr};
      end
    end
  end

  // one-cycle done pulse, latency set by the bench
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      cnt      <= 4'h0;
      bp_done  <= 1'b0;
      bp_rdata <= 64'h0;
    end
    else
    begin
      cnt      <= next_cnt;
      bp_done  <= next_done;
      bp_rdata <= next_rdata;
    end
endmodule
`default_nettype wire

// ==== verif/bamp_adapter_test.sv ====
`timescale 1ns/1ns
`default_nettype none
module bamp_adapter_test;
  import bamp_pkg::*;
  logic         pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic         ub_ack, bp_valid, bp_done, e;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata, r32;
  logic [15:0]  ub_rdata, r16;
  logic [63:0]  bp_rdata, pat;
  logic [3:0]   lat;
  bamp_ub_in_t  ub_in;
  bamp_bp_req_t bp_cmd, last;
  int           errors, comparisons, n_bp, base, cycles, k;

  bamp_adapter DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ub_in(ub_in), .ub_ack(ub_ack), .ub_rdata(ub_rdata),
    .bp_valid(bp_valid), .bp_cmd(bp_cmd), .bp_done(bp_done), .bp_rdata(bp_rdata));
  bamp_mem_model mem (.pclk(pclk), .presetn(presetn), .lat(lat), .bp_valid(bp_valid),
    .bp_cmd(bp_cmd), .bp_done(bp_done), .bp_rdata(bp_rdata));

  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // record each completed backplane transfer
  always @(posedge pclk)
    if (bp_valid === 1'b1 && bp_done === 1'b1)
    begin
      last <= bp_cmd;
      n_bp <= n_bp + 1;
    end

  // hang guard, far above the expected run
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      errors++;
      wrap_up();
    end
  end

  task automatic wrap_up;
    if (errors == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_cmd(input logic [27:0] a, input bamp_func_t f);
    chk(last.addr, a);
    chk(last.func, f);
  endtask

  // one apb transfer, request held until pready is sampled
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r32 = prdata;
    e   = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(r32, exp);
  endtask

  // one peripheral cycle; an unanswered cycle is dropped after 60 cycles
  task automatic ub(input logic [17:0] a, input logic [1:0] c, input logic [15:0] d,
                    input logic ack_exp);
    int n;
    n = 0;
    @(posedge pclk);
    ub_in.addr  <= a;
    ub_in.ctl   <= c;
    ub_in.wdata <= d;
    @(posedge pclk);
    ub_in.msyn <= 1'b1;
    while (ub_ack !== 1'b1 && n < 60)
    begin
      @(posedge pclk);
      n++;
    end
    chk(ub_ack, ack_exp);
    r16 = ub_rdata;
    ub_in.msyn <= 1'b0;
    while (ub_ack === 1'b1) @(posedge pclk);
    repeat (4) @(posedge pclk);
  endtask

  function automatic logic [31:0] ent(input logic [20:0] pg, input logic [3:0] path);
    return {1'b1, 6'h00, path, pg};
  endfunction

  initial
  begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    ub_in = '0;
    lat = 4'h1;
    n_bp = 0;
    presetn = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    // direct page 5, invalid page 6, buffered pages 8 and 9
    // each buffered path is given to one device only
    apb(1'b1, 12'h014, ent(21'h12345, 4'h0));
    apb(1'b1, 12'h018, 32'h00000000);
    apb(1'b1, 12'h020, ent(21'h0ABCD, 4'h3));
    apb(1'b1, 12'h024, ent(21'h1F00F, 4'h4));
    rd(12'h014, ent(21'h12345, 4'h0));
    rd(12'hFFC, 32'h0);
    chk(e, 1'b1);
    // direct word write, upper pair
    ub({9'd5, 7'h15, 2'b10}, 2'h2, 16'hBEEF, 1'b1);
    chk(n_bp, 1);
    chk_cmd({21'h12345, 7'h15}, BAMP_F_WRITE_MASK);
    chk({last.mask[3:0], last.wdata[31:0]}, 36'hCBEEFBEEF);
    // direct input cycle against a slow memory
    lat <= 4'h5;
    ub({9'd5, 7'h16, 2'b00}, 2'h0, 16'h0, 1'b1);
    chk_cmd({21'h12345, 7'h16}, BAMP_F_READ_MASK);
    chk(last.mask[3:0], 4'h3);
    chk(r16, {9'h145, 7'h16});
    lat <= 4'h1;
    // pause input, locked byte write, then a plain byte write
    ub({9'd5, 7'h17, 2'b10}, 2'h1, 16'h0, 1'b1);
    chk_cmd({21'h12345, 7'h17}, BAMP_F_ILK_READ_MASK);
    chk(last.mask[3:0], 4'hC);
    ub({9'd5, 7'h17, 2'b11}, 2'h3, 16'h5A5A, 1'b1);
    chk_cmd({21'h12345, 7'h17}, BAMP_F_ILK_WRITE_MASK);
    chk(last.mask[3:0], 4'h8);
    ub({9'd5, 7'h17, 2'b01}, 2'h3, 16'h5A5A, 1'b1);
    chk_cmd({21'h12345, 7'h17}, BAMP_F_WRITE_MASK);
    chk(last.mask[3:0], 4'h2);
    // invalid entry: no answer, flag set and cleared
    ub({9'd6, 9'h000}, 2'h2, 16'h1, 1'b0);
    rd(12'h800, 32'h1);
    apb(1'b1, 12'h800, 32'h1);
    rd(12'h800, 32'h0);
    // entry stored with bad parity
    apb(1'b1, 12'h804, 32'h1);
    apb(1'b1, 12'h01C, ent(21'h00077, 4'h0));
    apb(1'b1, 12'h804, 32'h0);
    ub({9'd7, 9'h000}, 2'h0, 16'h0, 1'b0);
    rd(12'h800, 32'h2);
    apb(1'b1, 12'h800, 32'h2);
    // buffered path: pause refused, then four words gathered
    base = n_bp;
    ub({9'd8, 9'h010}, 2'h1, 16'h0, 1'b0);
    for (k = 0; k < 4; k++)
    begin
      ub({9'd8, 6'h02, k[1:0], 1'b0}, 2'h2, 16'h1000 + k[15:0], 1'b1);
      if (k == 0)
        rd(12'h808, 32'h8);
    end
    k = 0;
    while (n_bp == base && k < 50)
    begin
      @(posedge pclk);
      k++;
    end
    chk(n_bp, base + 1);
    chk_cmd({21'h0ABCD, 6'h02, 1'b0}, BAMP_F_EXT_WRITE);
    chk({last.mask, last.wdata}, 72'hFF_1003_1002_1001_1000);
    rd(12'h808, 32'h0);
    // buffered read: miss fetches a quadword, next word hits
    ub({9'd9, 6'h05, 2'b10, 1'b0}, 2'h0, 16'h0, 1'b1);
    chk_cmd({21'h1F00F, 6'h05, 1'b0}, BAMP_F_EXT_READ);
    pat = {4'hC, 21'h1F00F, 7'h0A, 4'h3, 21'h1F00F, 7'h0A};
    chk(r16, pat[47:32]);
    base = n_bp;
    ub({9'd9, 6'h05, 2'b11, 1'b0}, 2'h0, 16'h0, 1'b1);
    chk(n_bp, base);
    chk(r16, pat[63:48]);
    wrap_up();
  end
endmodule
`default_nettype wire
